// ==== logic/gpio_pin_port_with_wake_irq.sv ====
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module gpio_pin_port_with_wake_irq #(
  parameter int NPINS = 32
) (
  // Clock and reset.
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  // Register port.
  input  wire logic [7:0]                      reg_addr,
  input  wire logic [31:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [31:0]                     reg_rdata,
  // Pad side.
  input  wire logic [NPINS-1:0]                pad_in,
  output logic      [NPINS-1:0]                pad_out,
  output logic      [NPINS-1:0]                pad_oe,
  output logic      [NPINS-1:0]                pull_up_en,
  output logic      [NPINS-1:0]                pull_dn_en,
  output logic      [2*NPINS-1:0]              pad_drive,
  // Peripheral side.
  input  wire logic [NPINS-1:0]                alt_out,
  input  wire logic [NPINS-1:0]                alt_oe,
  output logic      [NPINS-1:0]                alt_en,
  output logic      [gpio_pkg::ALT_W*NPINS-1:0] alt_sel,
  output logic      [NPINS-1:0]                alt_in,
  // Interrupt and wake side.
  input  gpio_pkg::power_state_e               power_state,
  output logic      [NPINS-1:0]                irq_pending,
  output logic      [2:0]                      irq_level,
  output logic      [4:0]                      irq_pin,
  output logic                                 wake
);
  import gpio_pkg::*;

  //////////////////////////////////////////////////////////////////////////

  pin_mode_e        mode_q  [NPINS];
  pin_mode_e        mode_d  [NPINS];
  logic [1:0]       pull_q  [NPINS];
  logic [1:0]       pull_d  [NPINS];
  logic [1:0]       drv_q   [NPINS];
  logic [1:0]       drv_d   [NPINS];
  logic [ALT_W-1:0] alt_q   [NPINS];
  logic [ALT_W-1:0] alt_d   [NPINS];
  logic [NPINS-1:0] obuf_q;
  logic [NPINS-1:0] obuf_d;
  logic [3:0]       trig_q  [NPINS];
  logic [3:0]       trig_d  [NPINS];
  logic [2:0]       prio_q  [NPINS];
  logic [2:0]       prio_d  [NPINS];
  logic [NPINS-1:0] en_q;
  logic [NPINS-1:0] en_d;
  logic [NPINS-1:0] deep_q;
  logic [NPINS-1:0] deep_d;
  logic [NPINS-1:0] pend_q;
  logic [NPINS-1:0] pend_d;
  logic [4:0]       susp_pin_q;
  logic [4:0]       susp_pin_d;
  logic             susp_vld_q;
  logic             susp_vld_d;
  logic [2:0]       lvl_q;
  logic [2:0]       lvl_d;
  logic [4:0]       lpin_q;
  logic [4:0]       lpin_d;
  logic             wake_q;
  logic             wake_d;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic [NPINS-1:0] pad_sync;
  logic [NPINS-1:0] trig_src;
  logic [NPINS-1:0] pin_event;
  logic             wr_pin_cfg;
  logic             wr_irq_cfg;
  logic [4:0]       widx;

  // Tells whether a mode hands the pad to a peripheral.
  function automatic logic is_alt(input pin_mode_e m);
    return (m == mode_alt) || (m == mode_alt_od);
  endfunction

  // Tells whether a word address falls in a per-pin window.
  function automatic logic in_window(input logic [7:0] a,
                                     input logic [7:0] base);
    return (a[7:5] == base[7:5]) && (int'(a[4:0]) < NPINS);
  endfunction

  //////////////////////////////////////////////////////////////////////////

  pin_sync #(
    .W        (NPINS)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  // Write decode shared by both configuration groups.
  assign wr_pin_cfg = reg_wr && in_window(reg_addr, ADDR_PIN_CFG_BASE);
  assign wr_irq_cfg = reg_wr && in_window(reg_addr, ADDR_IRQ_CFG_BASE);
  assign widx       = reg_addr[4:0];

  //////////////////////////////////////////////////////////////////////////

  // Next pin configuration and output buffer.
  always_comb begin
    pin_mode_e nm;
    nm = mode_in;
    obuf_d = obuf_q;
    if (reg_wr && reg_addr == ADDR_OUT_VALUE) begin
      obuf_d = reg_wdata[NPINS-1:0];
    end
    for (int i = 0; i < NPINS; i++) begin
      mode_d[i] = mode_q[i];
      pull_d[i] = pull_q[i];
      drv_d[i]  = drv_q[i];
      alt_d[i]  = alt_q[i];
      if (wr_pin_cfg && int'(widx) == i) begin
        if (reg_wdata[MODE_VLD] &&
            reg_wdata[MODE_LSB+:3] <= 3'(mode_alt_od)) begin
          mode_d[i] = pin_mode_e'(reg_wdata[MODE_LSB+:3]);
        end
        if (reg_wdata[PULL_VLD] && reg_wdata[PULL_LSB+:2] != 2'h3) begin
          pull_d[i] = reg_wdata[PULL_LSB+:2];
        end
        if (reg_wdata[DRV_VLD] && reg_wdata[DRV_LSB+:2] != 2'h3) begin
          drv_d[i] = reg_wdata[DRV_LSB+:2];
        end
        if (reg_wdata[ALT_VLD]) begin
          alt_d[i] = reg_wdata[ALT_LSB+:ALT_W];
        end
        nm = mode_d[i];
        if (reg_wdata[VAL_VLD] && (nm == mode_out || nm == mode_od)) begin
          obuf_d[i] = reg_wdata[VAL_BIT];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      obuf_q <= '0;
      for (int i = 0; i < NPINS; i++) begin
        mode_q[i] <= mode_in;
        pull_q[i] <= RST_PULL;
        drv_q[i]  <= RST_DRIVE;
        alt_q[i]  <= '0;
      end
    end else begin
      obuf_q <= obuf_d;
      for (int i = 0; i < NPINS; i++) begin
        mode_q[i] <= mode_d[i];
        pull_q[i] <= pull_d[i];
        drv_q[i]  <= drv_d[i];
        alt_q[i]  <= alt_d[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // Pad driver, pulls, drive and peripheral connection per pin.
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pad_out[i]          = 1'b0;
      pad_oe[i]           = 1'b0;
      alt_en[i]           = is_alt(mode_q[i]);
      alt_sel[i*ALT_W+:ALT_W] = '0;
      pull_up_en[i]       = (pull_q[i] == PULL_UP);
      pull_dn_en[i]       = (pull_q[i] == PULL_DOWN);
      pad_drive[2*i+:2]   = drv_q[i];
      alt_in[i]           = is_alt(mode_q[i]) & pad_sync[i];
      case (mode_q[i])
        mode_in: begin
          pad_oe[i] = 1'b0;
        end
        mode_out: begin
          pad_out[i] = obuf_q[i];
          pad_oe[i]  = 1'b1;
        end
        mode_od: begin
          pad_oe[i] = ~obuf_q[i];
        end
        mode_alt: begin
          pad_out[i]              = alt_out[i];
          pad_oe[i]               = alt_oe[i];
          alt_sel[i*ALT_W+:ALT_W] = alt_q[i];
        end
        mode_alt_od: begin
          pad_oe[i]               = alt_oe[i] & ~alt_out[i];
          alt_sel[i*ALT_W+:ALT_W] = alt_q[i];
        end
        default: begin
          pad_oe[i] = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      case (mode_q[i])
        mode_out: trig_src[i] = obuf_q[i];
        mode_od:  trig_src[i] = obuf_q[i] & pad_sync[i];
        default:  trig_src[i] = pad_sync[i];
      endcase
    end
  end

  // One detector per pin.
  for (genvar g = 0; g < NPINS; g++) begin : g_det
    pin_irq_unit u_det (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .src       (trig_src[g]),
      .trig      (trig_q[g]),
      .event_hit (pin_event[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////

  // Next interrupt configuration, pending flags and wake selection.
  always_comb begin
    logic [NPINS-1:0] set_v;
    logic [NPINS-1:0] clr_v;
    set_v      = '0;
    clr_v      = '0;
    susp_pin_d = susp_pin_q;
    susp_vld_d = susp_vld_q;
    if (reg_wr && reg_addr == ADDR_IRQ_SWTRIG) begin
      set_v = reg_wdata[NPINS-1:0];
    end
    if (reg_wr && reg_addr == ADDR_IRQ_STATUS) begin
      clr_v = reg_wdata[NPINS-1:0];
    end
    for (int i = 0; i < NPINS; i++) begin
      trig_d[i] = trig_q[i];
      prio_d[i] = prio_q[i];
      en_d[i]   = en_q[i];
      deep_d[i] = deep_q[i];
      if (wr_irq_cfg && int'(widx) == i) begin
        trig_d[i] = reg_wdata[TRIG_LSB+:4];
        // priority kept within 1 to 7.
        prio_d[i] = (reg_wdata[PRIO_LSB+:3] == 3'h0) ? PRIO_MIN
                                                     : reg_wdata[PRIO_LSB+:3];
        en_d[i]   = reg_wdata[EN_BIT];
        // every wake pin may be armed for deep; suspend arms only one pin at a time.
        deep_d[i] = reg_wdata[WDEEP_BIT] & is_wake_pin(i);
        if (reg_wdata[WSUSP_BIT] && is_wake_pin(i)) begin
          susp_pin_d = 5'(i);
          susp_vld_d = 1'b1;
        end else if (susp_pin_q == 5'(i)) begin
          susp_vld_d = 1'b0;
        end
        set_v[i] = set_v[i] | reg_wdata[SWTRG_BIT];
      end
      set_v[i] = set_v[i] | (en_q[i] & pin_event[i]);
    end
    // A new event wins over a clear in the same cycle.
    pend_d = (pend_q & ~clr_v) | set_v;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en_q       <= '0;
      deep_q     <= '0;
      pend_q     <= '0;
      susp_pin_q <= '0;
      susp_vld_q <= 1'b0;
      for (int i = 0; i < NPINS; i++) begin
        trig_q[i] <= RST_TRIG;
        prio_q[i] <= RST_PRIO;
      end
    end else begin
      en_q       <= en_d;
      deep_q     <= deep_d;
      pend_q     <= pend_d;
      susp_pin_q <= susp_pin_d;
      susp_vld_q <= susp_vld_d;
      for (int i = 0; i < NPINS; i++) begin
        trig_q[i] <= trig_d[i];
        prio_q[i] <= prio_d[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // Highest priority pending pin, lowest index on a tie, and wake request.
  always_comb begin
    lvl_d  = 3'h0;
    lpin_d = 5'h00;
    wake_d = 1'b0;
    for (int i = 0; i < NPINS; i++) begin
      if (pend_q[i] && prio_q[i] > lvl_d) begin
        lvl_d  = prio_q[i];
        lpin_d = 5'(i);
      end
      case (power_state)
        power_state_active: wake_d = wake_d | (pend_q[i] & en_q[i]);
        power_state_suspend: wake_d = wake_d | (pend_q[i] & susp_vld_q &
                                                (susp_pin_q == 5'(i)));
        power_state_deep: wake_d = wake_d | (pend_q[i] & deep_q[i]);
        default: wake_d = wake_d;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lvl_q  <= 3'h0;
      lpin_q <= 5'h00;
      wake_q <= 1'b0;
    end else begin
      lvl_q  <= lvl_d;
      lpin_q <= lpin_d;
      wake_q <= wake_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // Read data for the cycle after a read strobe; zero otherwise.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (in_window(reg_addr, ADDR_PIN_CFG_BASE)) begin
        rdata_d[MODE_LSB+:3]     = 3'(mode_q[widx]);
        rdata_d[PULL_LSB+:2]     = pull_q[widx];
        rdata_d[DRV_LSB+:2]      = drv_q[widx];
        rdata_d[ALT_LSB+:ALT_W]  = alt_q[widx];
        rdata_d[VAL_BIT]         = obuf_q[widx];
      end else if (in_window(reg_addr, ADDR_IRQ_CFG_BASE)) begin
        rdata_d[TRIG_LSB+:4]     = trig_q[widx];
        rdata_d[PRIO_LSB+:3]     = prio_q[widx];
        rdata_d[EN_BIT]          = en_q[widx];
        rdata_d[WSUSP_BIT]       = susp_vld_q & (susp_pin_q == widx);
        rdata_d[WDEEP_BIT]       = deep_q[widx];
      end else begin
        case (reg_addr)
          ADDR_OUT_VALUE:  rdata_d[NPINS-1:0] = obuf_q;
          ADDR_IN_VALUE:   rdata_d[NPINS-1:0] = pad_sync;
          ADDR_IRQ_STATUS: rdata_d[NPINS-1:0] = pend_q;
          ADDR_IRQ_ACTIVE: rdata_d[7:0]       = {lpin_q, lvl_q};
          default:         rdata_d            = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Registered outputs.
  assign reg_rdata   = rdata_q;
  assign irq_pending = pend_q;
  assign irq_level   = lvl_q;
  assign irq_pin     = lpin_q;
  assign wake        = wake_q;

endmodule

// ==== logic/pin_irq_unit.sv ====
`timescale 1ns/1ps
module pin_irq_unit (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Trigger source level and enabled trigger conditions.
  input  wire logic       src,
  input  wire logic [3:0] trig,
  // Detected condition, valid in the current cycle.
  output logic            event_hit
);
  import gpio_pkg::*;

  logic prev_q;
  logic prev_d;
  logic seen_q;
  logic seen_d;

  // Remember the last level; no edge is reported before one sample exists.
  always_comb begin
    prev_d = src;
    seen_d = 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      seen_q <= seen_d;
    end
  end

  always_comb begin
    event_hit = (trig[TRIG_FALL] & seen_q & prev_q & ~src) |
                (trig[TRIG_RISE] & seen_q & ~prev_q & src) |
                (trig[TRIG_LOW] & ~src) |
                (trig[TRIG_HIGH] & src);
  end

endmodule

// ==== logic/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 32
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Asynchronous levels in, aligned levels out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Two stages of flip-flops.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ==== pkg/gpio_pkg.sv ====
package gpio_pkg;

  // Pin modes held per pin.
  typedef enum logic [2:0] {
    mode_in,
    mode_out,
    mode_od,
    mode_alt,
    mode_alt_od
  } pin_mode_e;

  // Power state reported by the system controller.
  typedef enum logic [1:0] {
    power_state_active,
    power_state_suspend,
    power_state_deep
  } power_state_e;

  // Register word addresses.
  localparam logic [7:0] ADDR_PIN_CFG_BASE = 8'h00;
  localparam logic [7:0] ADDR_IRQ_CFG_BASE = 8'h20;
  localparam logic [7:0] ADDR_OUT_VALUE    = 8'h40;
  localparam logic [7:0] ADDR_IN_VALUE     = 8'h41;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h42;
  localparam logic [7:0] ADDR_IRQ_SWTRIG   = 8'h43;
  localparam logic [7:0] ADDR_IRQ_ACTIVE   = 8'h44;

  // Pin configuration word fields.
  localparam int MODE_LSB  = 0;
  localparam int MODE_VLD  = 3;
  localparam int PULL_LSB  = 4;
  localparam int PULL_VLD  = 6;
  localparam int DRV_LSB   = 7;
  localparam int DRV_VLD   = 9;
  localparam int ALT_LSB   = 10;
  localparam int ALT_VLD   = 14;
  localparam int VAL_BIT   = 15;
  localparam int VAL_VLD   = 16;
  localparam int ALT_W     = 4;

  // Interrupt configuration word fields.
  localparam int TRIG_LSB  = 0;
  localparam int PRIO_LSB  = 4;
  localparam int EN_BIT    = 7;
  localparam int WSUSP_BIT = 8;
  localparam int WDEEP_BIT = 9;
  localparam int SWTRG_BIT = 10;

  // Trigger bit positions inside the trigger field.
  localparam int TRIG_FALL = 0;
  localparam int TRIG_RISE = 1;
  localparam int TRIG_LOW  = 2;
  localparam int TRIG_HIGH = 3;

  // Pull and drive encodings.
  localparam logic [1:0] PULL_NONE       = 2'h0;
  localparam logic [1:0] PULL_UP         = 2'h1;
  localparam logic [1:0] PULL_DOWN       = 2'h2;
  localparam logic [1:0] DRIVE_LEVEL_LOW = 2'h0;
  localparam logic [1:0] drive_level_mid = 2'h1;
  localparam logic [1:0] DRIVE_LEVEL_HI  = 2'h2;

  // Values after reset.
  localparam logic [2:0] PRIO_MIN       = 3'h1;
  localparam logic [1:0] RST_PULL       = PULL_NONE;
  localparam logic [1:0] RST_DRIVE      = DRIVE_LEVEL_LOW;
  localparam logic [3:0] RST_TRIG       = 4'h3;
  localparam logic [2:0] RST_PRIO       = PRIO_MIN;

  // Pins that may wake the system from the lower power states.
  localparam int wake_pin_a = 2;
  localparam int wake_pin_b = 4;
  localparam int wake_pin_c = 10;
  localparam int wake_pin_d = 11;
  localparam int wake_pin_e = 17;
  localparam int wake_pin_f = 24;

  // Tells whether a pin index is one of the wake capable pins.
  function automatic logic is_wake_pin(input int idx);
    return (idx == wake_pin_a) || (idx == wake_pin_b) ||
           (idx == wake_pin_c) || (idx == wake_pin_d) ||
           (idx == wake_pin_e) || (idx == wake_pin_f);
  endfunction

endpackage

// ==== testbench/gpio_pin_port_with_wake_irq_assertions.sv ====
`timescale 1ns/1ps
// Watches pads, peripheral hand-over, read data and wake at the ports.
module gpio_chk
  import gpio_pkg::*;
#(
  parameter int NPINS = 32
) (
  // Clock and reset.
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // Register port.
  input wire logic                   reg_rd,
  input wire logic                   reg_wr,
  input wire logic [31:0]            reg_rdata,
  // Pad side.
  input wire logic [NPINS-1:0]       pad_out,
  input wire logic [NPINS-1:0]       pad_oe,
  input wire logic [NPINS-1:0]       pull_up_en,
  input wire logic [NPINS-1:0]       pull_dn_en,
  input wire logic [2*NPINS-1:0]     pad_drive,
  // Peripheral side.
  input wire logic [NPINS-1:0]       alt_out,
  input wire logic [NPINS-1:0]       alt_oe,
  input wire logic [NPINS-1:0]       alt_en,
  input wire logic [ALT_W*NPINS-1:0] alt_sel,
  input wire logic [NPINS-1:0]       alt_in,
  // Interrupt and wake side.
  input gpio_pkg::power_state_e      power_state,
  input wire logic [NPINS-1:0]       irq_pending,
  input wire logic [2:0]             irq_level,
  input wire logic                   wake
);
  import gpio_pkg::*;
  // Pins that may wake from the low power states.
  localparam logic [NPINS-1:0] WMASK = NPINS'(32'h01020c14);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // A read followed by an idle cycle.
  sequence s_lone_read;
    reg_rd ##1 !reg_rd;
  endsequence
  AST_PULL_EXCL: assert property (!(|(pull_up_en & pull_dn_en)))
    else $error("both pulls on");
  AST_DRIVE_CODE: assert property (pad_drive[1:0] != 2'h3)
    else $error("bad drive code");
  AST_ALT_SEL_IDLE: assert property (!alt_en[0] |-> alt_sel[3:0] == 4'h0)
    else $error("selector outside alternate");
  AST_ALT_IN_IDLE: assert property (!alt_en[0] |-> !alt_in[0])
    else $error("peripheral sees pad");
  AST_ALT_PAD: assert property (alt_en[0] && pad_oe[0] |->
    alt_oe[0] && pad_out[0] == alt_out[0])
    else $error("pad not from peripheral");
  AST_GPIO_OWNS: assert property (!alt_en[0] && !$past(reg_wr) &&
    $changed(alt_oe[0]) |-> $stable(pad_oe[0]))
    else $error("peripheral moved pad");
  AST_RDATA_CAUSE: assert property (reg_rdata != 0 |-> $past(reg_rd))
    else $error("data without read");
  AST_RDATA_DROP: assert property (s_lone_read |=> reg_rdata == 0)
    else $error("read data held");
  AST_LEVEL_TRACK: assert property (1 |=>
    (irq_level != 3'h0) == $past(|irq_pending))
    else $error("level not from pending");
  AST_WAKE_CAUSE: assert property ($rose(wake) |-> $past(|irq_pending))
    else $error("wake without pending");
  AST_LOW_WAKE: assert property ($rose(wake) &&
    $past(power_state) != power_state_active |->
    $past(|(irq_pending & WMASK)))
    else $error("low power wake off pin");
endmodule
bind gpio_pin_port_with_wake_irq gpio_chk #(.NPINS(NPINS)) u_chk (
  .ref_clk, .rst, .reg_rd, .reg_wr, .reg_rdata, .pad_out, .pad_oe,
  .pull_up_en, .pull_dn_en, .pad_drive, .alt_out, .alt_oe, .alt_en,
  .alt_sel, .alt_in, .power_state, .irq_pending, .irq_level, .wake);

// ==== testbench/pad_world.sv ====
`timescale 1ns/1ps
// Outside circuit on the pads: sources, pulls and floating lines.
module pad_world #(
  parameter int NPINS = 32
) (
  // Clock.
  input  wire logic             ref_clk,
  // From the pad drivers.
  input  wire logic [NPINS-1:0] pad_out,
  input  wire logic [NPINS-1:0] pad_oe,
  input  wire logic [NPINS-1:0] pull_up_en,
  input  wire logic [NPINS-1:0] pull_dn_en,
  // Outside sources.
  input  wire logic [NPINS-1:0] ext_val,
  input  wire logic [NPINS-1:0] ext_en,
  // Resolved pad level.
  output logic      [NPINS-1:0] pad_in
);
  logic [NPINS-1:0] last_q = '0;
  // driver, source, pull.
  // A floating pad flips each cycle so no stale level is read.
  always_comb begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
           | (~pad_oe & ~ext_en & (pull_up_en | (~pull_dn_en & ~last_q)));
  end
  // Remembers the last level for floating pads.
  always_ff @(posedge ref_clk) begin
    last_q <= pad_in;
  end
endmodule

// ==== testbench/tb_gpio_pin_port_with_wake_irq.sv ====
`timescale 1ns/1ps
// Drives register port, pads and peripheral, and judges the results.
module tb_gpio_pin_port_with_wake_irq;
  import gpio_pkg::*;
  localparam int NPINS = 32;
  // Design and partner signals.
  logic                   ref_clk = 1'b0;
  logic                   rst = 1'b1;
  logic [7:0]             reg_addr = 8'h00;
  logic [31:0]            reg_wdata = 32'h0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [31:0]            reg_rdata;
  logic [NPINS-1:0]       pad_in, pad_out, pad_oe, pull_up_en, pull_dn_en;
  logic [2*NPINS-1:0]     pad_drive;
  logic [NPINS-1:0]       alt_out = '0;
  logic [NPINS-1:0]       alt_oe = '0;
  logic [NPINS-1:0]       alt_en, alt_in, irq_pending;
  logic [ALT_W*NPINS-1:0] alt_sel;
  power_state_e           power_state = power_state_active;
  logic [2:0]             irq_level;
  logic [4:0]             irq_pin;
  logic                   wake;
  logic [NPINS-1:0]       ext_val = '0;
  logic [NPINS-1:0]       ext_en = '1;
  int                     fail_count = 0;
  int                     samples_checked = 0;
  gpio_pin_port_with_wake_irq #(.NPINS(NPINS)) uut (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pad_in, .pad_out, .pad_oe, .pull_up_en, .pull_dn_en, .pad_drive,
    .alt_out, .alt_oe, .alt_en, .alt_sel, .alt_in, .power_state,
    .irq_pending, .irq_level, .irq_pin, .wake);
  pad_world #(.NPINS(NPINS)) u_world (
    .ref_clk, .pad_out, .pad_oe, .pull_up_en, .pull_dn_en, .ext_val,
    .ext_en, .pad_in);
  // Clock of 50 ns.
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Compares a word and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Lets n edges pass and the outputs settle.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One write cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One read cycle, then a comparison of the answer.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Moves the outside level of pin 0.
  task automatic pad0(input logic v);
    @(posedge ref_clk);
    ext_val[0] <= v;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Values after reset and an unmapped read.
  task automatic t_reset();
    rchk(8'h00, 32'h0);
    rchk(8'h20, 32'h13);
    rchk(8'h7f, 32'h0);
    chk(pad_oe, '0);
  endtask
  // Buffer, output kinds, partial configuration and drive.
  task automatic t_gpio();
    pad0(1'b1);
    wr(8'h40, 32'h1);
    tick(3);
    chk(pad_oe[0], 1'b0);
    rchk(8'h41, 32'h1);
    rchk(8'h40, 32'h1);
    rchk(8'h00, 32'h8000);
    wr(8'h00, 32'h9);
    tick(1);
    chk({pad_oe[0], pad_out[0]}, 2'b11);
    wr(8'h40, 32'h0);
    tick(1);
    chk({pad_oe[0], pad_out[0]}, 2'b10);
    wr(8'h00, 32'ha);
    tick(1);
    chk({pad_oe[0], pad_out[0]}, 2'b10);
    wr(8'h40, 32'h1);
    tick(1);
    chk(pad_oe[0], 1'b0);
    wr(8'h00, 32'h50);
    rchk(8'h00, 32'h8012);
    wr(8'h00, 32'h60);
    tick(1);
    chk({pull_up_en[0], pull_dn_en[0]}, 2'b01);
    wr(8'h00, 32'h8);
    wr(8'h00, 32'h10000);
    rchk(8'h00, 32'h8020);
    wr(8'h00, 32'h1000a);
    rchk(8'h00, 32'h22);
    wr(8'h00, 32'h280);
    tick(1);
    chk(pad_drive[1:0], drive_level_mid);
    rchk(8'h00, 32'ha2);
  endtask
  // Alternate hand-over, open-drain alternate and return to gpio.
  task automatic t_alt();
    wr(8'h00, 32'h5400);
    tick(1);
    chk({alt_en[0], alt_sel[3:0]}, 5'h0);
    wr(8'h00, 32'hb);
    alt_out[0] <= 1'b1;
    alt_oe[0] <= 1'b1;
    tick(1);
    chk({alt_en[0], alt_sel[3:0], pad_oe[0], pad_out[0]}, 7'h57);
    wr(8'h00, 32'hc);
    tick(1);
    chk(pad_oe[0], 1'b0);
    chk(alt_in[0], 1'b1);
    @(posedge ref_clk);
    alt_out[0] <= 1'b0;
    tick(1);
    chk({pad_oe[0], pad_out[0]}, 2'b10);
    wr(8'h00, 32'h8);
    tick(1);
    chk({alt_en[0], pad_oe[0]}, 2'b00);
    @(posedge ref_clk);
    alt_oe[0] <= 1'b0;
  endtask
  // Every trigger kind, disable and software trigger on pin 0.
  task automatic t_irq();
    logic idle;
    for (int k = 0; k < 4; k++) begin
      idle = (k % 2 == 0);
      pad0(idle);
      tick(4);
      wr(8'h20, 32'hd0 | (32'h1 << k));
      wr(8'h42, 32'h1);
      tick(2);
      chk(irq_pending[0], 1'b0);
      pad0(~idle);
      tick(6);
      chk({irq_pending[0], irq_level, irq_pin}, 9'h1a0);
    end
    wr(8'h20, 32'h52);
    pad0(1'b0);
    wr(8'h42, 32'h1);
    pad0(1'b1);
    tick(6);
    chk(irq_pending[0], 1'b0);
    wr(8'h20, 32'hd2);
    wr(8'h43, 32'h1);
    tick(2);
    chk(irq_pending[0], 1'b1);
    wr(8'h42, 32'h1);
    // Push-pull output: the buffer is the trigger source.
    wr(8'h40, 32'h0);
    wr(8'h00, 32'h9);
    wr(8'h42, 32'h1);
    tick(4);
    chk(irq_pending[0], 1'b0);
    wr(8'h40, 32'h1);
    tick(4);
    chk(irq_pending[0], 1'b1);
    wr(8'h00, 32'h8);
    wr(8'h42, 32'h1);
  endtask
  // Wake in suspend, deep and active states.
  task automatic t_wake();
    wr(8'h22, 32'h1f2);
    wr(8'h24, 32'h1f2);
    @(posedge ref_clk);
    power_state <= power_state_suspend;
    wr(8'h43, 32'h4);
    tick(3);
    chk({wake, irq_pending[4:0]}, 6'h04);
    chk({irq_level, irq_pin}, 8'he2);
    rchk(8'h44, 32'h17);
    rchk(8'h42, 32'h4);
    wr(8'h42, 32'h14);
    wr(8'h43, 32'h10);
    tick(3);
    chk(wake, 1'b1);
    wr(8'h42, 32'h14);
    wr(8'h22, 32'h2f2);
    wr(8'h24, 32'h2f2);
    @(posedge ref_clk);
    power_state <= power_state_deep;
    wr(8'h43, 32'h4);
    tick(3);
    chk(wake, 1'b1);
    wr(8'h42, 32'h14);
    tick(3);
    chk(wake, 1'b0);
    wr(8'h43, 32'h10);
    tick(3);
    chk(wake, 1'b1);
    wr(8'h42, 32'h14);
    @(posedge ref_clk);
    power_state <= power_state_active;
    wr(8'h43, 32'h1);
    tick(3);
    chk(wake, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic results();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_gpio();
    t_alt();
    t_irq();
    t_wake();
    results();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #(50 * 20000);
    fail_count++;
    results();
  end
endmodule
